/* File: core/cfb_alu_flags.sv */
// Result and flag logic of the core ALU.
// Assumes operands are stable for the execute cycle; purely combinational.
`timescale 1ns/1ps
`include "cfb_regs.svh"

module cfb_alu_flags
(
	input  wire cfb_pkg::cfb_alu_op_e op,
	input  wire cfb_pkg::cfb_byte_t   opnd_a,
	input  wire cfb_pkg::cfb_byte_t   opnd_b,
	input  wire logic                 carry_in,
	output cfb_pkg::cfb_byte_t        result,
	output logic                      zero,
	output logic                      nibble_carry,
	output logic                      carry,
	output logic                      aff_zero,
	output logic                      aff_nibble,
	output logic                      aff_carry
);
	import cfb_pkg::*;

	cfb_byte_t   addend;
	logic        add_cin;
	logic [8:0]  sum9;
	logic [4:0]  sum5;

	// Subtraction adds the two's complement, so carry reads as no borrow
	always_comb
	begin
		addend  = opnd_b;
		add_cin = 1'b0;
		case (op)
			CFB_OP_SUB:
			begin
				addend  = ~opnd_b;
				add_cin = 1'b1;
			end
			CFB_OP_INC:
			begin
				addend  = 8'h01;
			end
			CFB_OP_DEC:
			begin
				addend  = 8'hFF;
			end
			default:
			begin
				addend  = opnd_b;
			end
		endcase
	end

	assign sum9 = {1'b0, opnd_a} + {1'b0, addend} + {8'h00, add_cin};
	assign sum5 = {1'b0, opnd_a[`CFB_NIBBLE_MSB:0]} + {1'b0, addend[`CFB_NIBBLE_MSB:0]}
		+ {4'h0, add_cin};

	always_comb
	begin
		result       = opnd_a;
		carry        = carry_in;
		nibble_carry = sum5[4];
		aff_zero     = 1'b0;
		aff_nibble   = 1'b0;
		aff_carry    = 1'b0;
		case (op)
			CFB_OP_ADD, CFB_OP_SUB:
			begin
				result     = sum9[`CFB_BYTE_MSB:0];
				carry      = sum9[8];
				aff_zero   = 1'b1;
				aff_nibble = 1'b1;
				aff_carry  = 1'b1;
			end
			CFB_OP_INC, CFB_OP_DEC:
			begin
				result   = sum9[`CFB_BYTE_MSB:0];
				aff_zero = 1'b1;
			end
			CFB_OP_AND:
			begin
				result   = opnd_a & opnd_b;
				aff_zero = 1'b1;
			end
			CFB_OP_IOR:
			begin
				result   = opnd_a | opnd_b;
				aff_zero = 1'b1;
			end
			CFB_OP_XOR:
			begin
				result   = opnd_a ^ opnd_b;
				aff_zero = 1'b1;
			end
			CFB_OP_COM:
			begin
				result   = ~opnd_a;
				aff_zero = 1'b1;
			end
			CFB_OP_MOVZ:
			begin
				aff_zero = 1'b1;
			end
			CFB_OP_CLR:
			begin
				result   = 8'h00;
				aff_zero = 1'b1;
			end
			CFB_OP_RLF:
			begin
				result    = {opnd_a[`CFB_BYTE_MSB-1:0], carry_in};
				carry     = opnd_a[`CFB_BYTE_MSB];
				aff_carry = 1'b1;
			end
			CFB_OP_RRF:
			begin
				result    = {carry_in, opnd_a[`CFB_BYTE_MSB:1]};
				carry     = opnd_a[0];
				aff_carry = 1'b1;
			end
			CFB_OP_SWAP:
			begin
				result = {opnd_a[`CFB_NIBBLE_MSB:0], opnd_a[`CFB_BYTE_MSB:4]};
			end
			default:
			begin
				result = opnd_a;
			end
		endcase
		zero = (result == 8'h00);
	end

endmodule

/* File: core/cfb_pkg.sv */
// Types for the core flags and bank select register.
// Assumes the constant header sits on the include path.
`include "cfb_regs.svh"

package cfb_pkg;

	typedef logic [`CFB_DATA_W-1:0] cfb_byte_t;
	typedef logic [`CFB_OFS_W-1:0]  cfb_ofs_t;
	typedef logic [`CFB_PHYS_W-1:0] cfb_phys_t;

	typedef enum logic [3:0]
	{
		CFB_OP_PASS = 4'h0,
		CFB_OP_SWAP = 4'h1,
		CFB_OP_ADD  = 4'h2,
		CFB_OP_SUB  = 4'h3,
		CFB_OP_AND  = 4'h4,
		CFB_OP_IOR  = 4'h5,
		CFB_OP_XOR  = 4'h6,
		CFB_OP_COM  = 4'h7,
		CFB_OP_INC  = 4'h8,
		CFB_OP_DEC  = 4'h9,
		CFB_OP_RLF  = 4'hA,
		CFB_OP_RRF  = 4'hB,
		CFB_OP_CLR  = 4'hC,
		CFB_OP_MOVZ = 4'hD
	} cfb_alu_op_e;

endpackage

/* File: core/cfb_regs.svh */
// Constants for the core flags and bank select register.
// Assumes inclusion by bare name from the package and design files.
`ifndef CFB_REGS_SVH
`define CFB_REGS_SVH

`define CFB_DATA_W        8
`define CFB_OFS_W         7
`define CFB_PHYS_W        9
`define CFB_ADDR_LOW_MIR  8'h03
`define CFB_ADDR_HIGH_MIR 8'h83
`define CFB_BANK_BYTES    128
`define CFB_RESET_VAL     8'h18

`define CFB_BIT_IND       7
`define CFB_BIT_DIR_HI    6
`define CFB_BIT_DIR_LO    5
`define CFB_BIT_WDT       4
`define CFB_BIT_SLEEP     3
`define CFB_BIT_ZERO      2
`define CFB_BIT_NIBBLE    1
`define CFB_BIT_CARRY     0
`define CFB_NIBBLE_MSB    3
`define CFB_BYTE_MSB      7

`endif

/* File: core/cfb_status.sv */
// Core flags and bank select register with data-memory bank mapping.
// Assumes one execute strobe per instruction cycle from the core sequencer.
`timescale 1ns/1ps
`include "cfb_regs.svh"

// Summary of operation
// - Register answers at file addresses 03H and 83H
// - Bit 7 picks indirect bank pair
// - Bits 6-5 pick the direct bank
// - Banks span 128 bytes, instruction gives offset
// - Watchdog and sleep flags ignore data writes
// - Flag-affecting writes leave flags to flag logic
// - Carry flags mean no borrow in subtraction
// - Clear-file zeroes upper bits, sets zero flag
module cfb_status
#(
	parameter int DATA_W = `CFB_DATA_W,
	parameter int OFS_W  = `CFB_OFS_W
)
(
	input  wire logic                 clock,
	input  wire logic                 rst_b,
	input  wire logic                 exec_valid,
	input  wire logic                 acc_indirect,
	input  wire cfb_pkg::cfb_ofs_t    acc_file_addr,
	input  wire cfb_pkg::cfb_byte_t   acc_ptr_addr,
	input  wire logic                 dest_write,
	input  wire cfb_pkg::cfb_alu_op_e alu_op,
	input  wire cfb_pkg::cfb_byte_t   alu_a,
	input  wire cfb_pkg::cfb_byte_t   alu_b,
	input  wire logic                 wdt_expire,
	input  wire logic                 sleep_exec,
	input  wire logic                 clrwdt_exec,
	output cfb_pkg::cfb_byte_t        status_r,
	output cfb_pkg::cfb_phys_t        mem_addr_r,
	output logic                      status_hit_r,
	output cfb_pkg::cfb_byte_t        rd_data_r,
	output cfb_pkg::cfb_byte_t        result_r,
	output logic                      result_we_r
);
	import cfb_pkg::*;

	generate
		if (DATA_W != `CFB_DATA_W || OFS_W != `CFB_OFS_W)
		begin : g_bad_width
			$error("cfb_status supports only an 8-bit register and 7-bit offset");
		end
	endgenerate

	// Decode of the mirrored register address within a bank pair
	function automatic logic cfb_is_flags_addr(input cfb_phys_t addr);
		cfb_is_flags_addr = (addr[7:0] == `CFB_ADDR_LOW_MIR)
			|| (addr[7:0] == `CFB_ADDR_HIGH_MIR);
	endfunction

	cfb_byte_t  stat_nxt;
	cfb_phys_t  mem_addr_nxt;
	logic       status_hit_nxt;
	cfb_byte_t  rd_data_nxt;
	cfb_byte_t  result_nxt;
	logic       result_we_nxt;

	cfb_phys_t  phys_addr;
	logic       flags_hit;
	cfb_byte_t  alu_result;
	logic       alu_zero;
	logic       alu_nibble;
	logic       alu_carry;
	logic       aff_zero;
	logic       aff_nibble;
	logic       aff_carry;
	logic       aff_any;

	cfb_alu_flags u_alu
	(
		.op           (alu_op),
		.opnd_a       (alu_a),
		.opnd_b       (alu_b),
		.carry_in     (status_r[`CFB_BIT_CARRY]),
		.result       (alu_result),
		.zero         (alu_zero),
		.nibble_carry (alu_nibble),
		.carry        (alu_carry),
		.aff_zero     (aff_zero),
		.aff_nibble   (aff_nibble),
		.aff_carry    (aff_carry)
	);

	assign aff_any = aff_zero | aff_nibble | aff_carry;

	// Bank mapping of the data-memory address
	always_comb
	begin
		if (acc_indirect)
		begin
			phys_addr = {status_r[`CFB_BIT_IND], acc_ptr_addr};
		end
		else
		begin
			phys_addr = {status_r[`CFB_BIT_DIR_HI], status_r[`CFB_BIT_DIR_LO],
				acc_file_addr};
		end
		flags_hit = cfb_is_flags_addr(phys_addr);
	end

	// Next register value
	always_comb
	begin
		stat_nxt = status_r;
		if (exec_valid)
		begin
			if (dest_write && flags_hit)
			begin
				stat_nxt[`CFB_BIT_IND]    = alu_result[`CFB_BIT_IND];
				stat_nxt[`CFB_BIT_DIR_HI] = alu_result[`CFB_BIT_DIR_HI];
				stat_nxt[`CFB_BIT_DIR_LO] = alu_result[`CFB_BIT_DIR_LO];
				if (!aff_any)
				begin
					stat_nxt[`CFB_BIT_ZERO]   = alu_result[`CFB_BIT_ZERO];
					stat_nxt[`CFB_BIT_NIBBLE] = alu_result[`CFB_BIT_NIBBLE];
					stat_nxt[`CFB_BIT_CARRY]  = alu_result[`CFB_BIT_CARRY];
				end
			end
			if (aff_zero)
			begin
				stat_nxt[`CFB_BIT_ZERO] = alu_zero;
			end
			if (aff_nibble)
			begin
				stat_nxt[`CFB_BIT_NIBBLE] = alu_nibble;
			end
			if (aff_carry)
			begin
				stat_nxt[`CFB_BIT_CARRY] = alu_carry;
			end
		end
		// Watchdog and sleep flags move only on core events
		if (clrwdt_exec)
		begin
			stat_nxt[`CFB_BIT_WDT]   = 1'b1;
			stat_nxt[`CFB_BIT_SLEEP] = 1'b1;
		end
		if (sleep_exec)
		begin
			stat_nxt[`CFB_BIT_WDT]   = 1'b1;
			stat_nxt[`CFB_BIT_SLEEP] = 1'b0;
		end
		if (wdt_expire)
		begin
			stat_nxt[`CFB_BIT_WDT] = 1'b0;
		end
	end

	// Access side outputs
	always_comb
	begin
		mem_addr_nxt   = mem_addr_r;
		status_hit_nxt = 1'b0;
		rd_data_nxt    = rd_data_r;
		result_nxt     = result_r;
		result_we_nxt  = 1'b0;
		if (exec_valid)
		begin
			mem_addr_nxt   = phys_addr;
			status_hit_nxt = flags_hit;
			rd_data_nxt    = flags_hit ? status_r : 8'h00;
			result_nxt     = alu_result;
			result_we_nxt  = dest_write && !flags_hit;
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			status_r     <= `CFB_RESET_VAL;
			mem_addr_r   <= 9'h000;
			status_hit_r <= 1'b0;
			rd_data_r    <= 8'h00;
			result_r     <= 8'h00;
			result_we_r  <= 1'b0;
		end
		else
		begin
			status_r     <= stat_nxt;
			mem_addr_r   <= mem_addr_nxt;
			status_hit_r <= status_hit_nxt;
			rd_data_r    <= rd_data_nxt;
			result_r     <= result_nxt;
			result_we_r  <= result_we_nxt;
		end
	end

endmodule

/* File: sim/cfb_core_model.sv */
// Core sequencer model issuing random instructions.
// Assumes run rises only after reset release.
`timescale 1ns/1ps
module cfb_core_model
(
	input  wire logic            clock,
	input  wire logic            run,
	output logic                 exec_valid,
	output logic                 acc_indirect,
	output cfb_pkg::cfb_ofs_t    acc_file_addr,
	output cfb_pkg::cfb_byte_t   acc_ptr_addr,
	output logic                 dest_write,
	output cfb_pkg::cfb_alu_op_e alu_op,
	output cfb_pkg::cfb_byte_t   alu_a,
	output cfb_pkg::cfb_byte_t   alu_b,
	output logic                 wdt_expire,
	output logic                 sleep_exec,
	output logic                 clrwdt_exec
);
	import cfb_pkg::*;
	cfb_alu_op_e op;
	cfb_byte_t   a, b;
	logic        safe;
	initial
	begin
		{exec_valid, acc_indirect, acc_file_addr, acc_ptr_addr, dest_write} = '0;
		{alu_a, alu_b, wdt_expire, sleep_exec, clrwdt_exec} = '0;
		alu_op = CFB_OP_PASS;
		void'($urandom(32'hF1D7));
		forever
		begin
			@(posedge clock);
			op = cfb_alu_op_e'($urandom_range(13));
			a = 8'($urandom) >> 3 * $urandom_range(1);
			b = 8'($urandom) >> 3 * $urandom_range(1);
			safe = op inside {CFB_OP_PASS, CFB_OP_ADD, CFB_OP_AND, CFB_OP_IOR, CFB_OP_XOR,
				CFB_OP_INC, CFB_OP_RLF, CFB_OP_MOVZ} && a < 8'h20 && b < 8'h20;
			exec_valid <= run && $urandom_range(1);
			acc_indirect <= $urandom_range(3) == 0;
			acc_file_addr <= $urandom_range(1) ? 7'h03 : 7'($urandom);
			acc_ptr_addr <= 8'($urandom);
			alu_op <= op;
			alu_a <= a;
			alu_b <= b;
			dest_write <= $urandom_range(1) && (op == CFB_OP_CLR || safe);
			wdt_expire <= run && $urandom_range(31) == 0;
			sleep_exec <= run && $urandom_range(31) == 0;
			clrwdt_exec <= run && $urandom_range(15) == 0;
		end
	end
endmodule

/* File: sim/cfb_status_properties.sv */
// Assertions on the core flags register ports.
// Assumes binding onto every register instance.
`timescale 1ns/1ps
module cfb_status_properties
(
	input wire logic                 clock,
	input wire logic                 rst_b,
	input wire logic                 exec_valid,
	input wire logic                 acc_indirect,
	input wire cfb_pkg::cfb_ofs_t    acc_file_addr,
	input wire cfb_pkg::cfb_byte_t   acc_ptr_addr,
	input wire logic                 dest_write,
	input wire cfb_pkg::cfb_alu_op_e alu_op,
	input wire cfb_pkg::cfb_byte_t   alu_a,
	input wire cfb_pkg::cfb_byte_t   alu_b,
	input wire logic                 wdt_expire,
	input wire logic                 sleep_exec,
	input wire logic                 clrwdt_exec,
	input wire cfb_pkg::cfb_byte_t   status_r,
	input wire cfb_pkg::cfb_phys_t   mem_addr_r,
	input wire logic                 status_hit_r,
	input wire cfb_pkg::cfb_byte_t   rd_data_r,
	input wire cfb_pkg::cfb_byte_t   result_r,
	input wire logic                 result_we_r
);
	import cfb_pkg::*;
	cfb_phys_t map_c;
	assign map_c = acc_indirect ? {status_r[7], acc_ptr_addr} : {status_r[6:5], acc_file_addr};
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence quiet_s;
		!(wdt_expire || sleep_exec || clrwdt_exec);
	endsequence
	sequence clr_hit_s;
		exec_valid && dest_write && alu_op == CFB_OP_CLR ##1 status_hit_r;
	endsequence
	addr_map_a: assert property (exec_valid |=> mem_addr_r == $past(map_c))
		else $error("mapped address");
	hit_decode_a: assert property (exec_valid |=> status_hit_r == (mem_addr_r[6:0] == 7'h03))
		else $error("decode");
	pulse_idle_a: assert property (!exec_valid |=> !status_hit_r && !result_we_r)
		else $error("stray pulse");
	flags_ro_a: assert property (quiet_s |=> $stable(status_r[4:3]))
		else $error("read-only bits");
	expiry_clear_a: assert property (wdt_expire |=> !status_r[4])
		else $error("expiry");
	clr_file_a: assert property (clr_hit_s |-> status_r[7:5] == 3'b000 && status_r[2])
		else $error("clear file");
	rd_old_a: assert property (status_hit_r |-> rd_data_r == $past(status_r))
		else $error("read data");
	write_route_a: assert property (exec_valid |=>
		result_we_r == ($past(dest_write) && !status_hit_r))
		else $error("write route");
endmodule

bind cfb_status cfb_status_properties chk (.*);

/* File: sim/tb.sv */
// Self-checking bench for the core flags register.
// Assumes the core model drives the execute side.
`timescale 1ns/1ps
module tb;
	import cfb_pkg::*;
	logic        clock = 1'b0;
	logic        rst_b = 1'b0;
	logic        run = 1'b0;
	logic        exec_valid, acc_indirect, dest_write, wdt_expire, sleep_exec, clrwdt_exec;
	logic        status_hit_r, result_we_r;
	cfb_ofs_t    acc_file_addr;
	cfb_byte_t   acc_ptr_addr, alu_a, alu_b, status_r, rd_data_r, result_r;
	cfb_alu_op_e alu_op;
	cfb_phys_t   mem_addr_r;
	int          err_total, comparisons, cyc, s = 'h18, a, r, d, h;
	int          q[$];
	wire [26:0]  obs = {status_hit_r, result_we_r, rd_data_r, mem_addr_r, result_r};

	cfb_status dut (.*);
	cfb_core_model core (.*);

	initial
	begin
		forever #2.5 clock = ~clock;
	end

	task automatic check(logic [31:0] got, logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task report_and_stop;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge clock or negedge rst_b)
		if (!rst_b)
		begin
			s = 'h18;
			q.delete();
		end
		else
		begin
			if (exec_valid)
			begin
				a = acc_indirect ? s[7] << 8 | acc_ptr_addr : s[6:5] << 7 | acc_file_addr;
				case (alu_op)
					CFB_OP_ADD: r = alu_a + alu_b;
					CFB_OP_SUB: r = alu_a + (~alu_b & 255) + 1;
					CFB_OP_INC: r = alu_a + 1;
					CFB_OP_DEC: r = alu_a + 255;
					CFB_OP_AND: r = alu_a & alu_b;
					CFB_OP_IOR: r = alu_a | alu_b;
					CFB_OP_XOR: r = alu_a ^ alu_b;
					CFB_OP_COM: r = ~alu_a & 255;
					CFB_OP_RLF: r = alu_a << 1 | s[0];
					CFB_OP_RRF: r = (alu_a & 1) << 8 | s[0] << 7 | alu_a >> 1;
					CFB_OP_SWAP: r = (alu_a & 15) << 4 | alu_a >> 4;
					CFB_OP_PASS, CFB_OP_MOVZ: r = alu_a;
					default: r = 0;
				endcase
				d = alu_op == CFB_OP_SUB ? (~alu_b & 15) + 1 : alu_b & 15;
				d = (alu_a & 15) + d >> 4;
				h = (a & 127) == 3;
				q.push_back(h << 26 | (dest_write && !h) << 25 | (h ? s : 0) << 17 | a << 8 | r & 255);
				if (dest_write && h)
					s = s & 'h18 | r & 'hE0 | (alu_op inside {CFB_OP_PASS, CFB_OP_SWAP} ? r : s) & 7;
				if (alu_op inside {CFB_OP_ADD, CFB_OP_SUB, CFB_OP_CLR, CFB_OP_INC, CFB_OP_DEC,
					CFB_OP_AND, CFB_OP_IOR, CFB_OP_XOR, CFB_OP_COM, CFB_OP_MOVZ})
					s[2] = (r & 255) == 0;
				if (alu_op inside {CFB_OP_ADD, CFB_OP_SUB})
					s[1] = d[0];
				if (alu_op inside {CFB_OP_ADD, CFB_OP_SUB, CFB_OP_RLF, CFB_OP_RRF})
					s[0] = r[8];
			end
			if (clrwdt_exec)
				s[4:3] = 3;
			if (sleep_exec)
				s[4:3] = 2;
			if (wdt_expire)
				s[4] = 0;
		end

	always @(negedge clock)
		if (rst_b)
		begin
			check(status_r, s);
			if (q.size() > 0)
				check(obs, q.pop_front());
		end
		else
		begin
			check(status_r, 'h18);
			check(obs, 0);
		end

	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			report_and_stop;
		end
	end

	initial
	begin
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		run <= 1'b1;
		repeat (1000) @(posedge clock);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		repeat (1000) @(posedge clock);
		report_and_stop;
	end
endmodule
